/* File: rtl/flash_self_program_sequencer.sv */
// The register offsets and the AXI4-Lite register port were decided locally.
module flash_self_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC_DEF,
    parameter int PROG_CYCLES  = PROG_CYC_DEF
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // AXI4-Lite write channels
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Core table instruction port
    input  wire logic        tblReq,
    input  wire logic        tblWrite,
    input  wire logic [1:0]  tblMode,
    output logic             tblDone,
    output logic [7:0]       tableByteLatch,
    output logic             cpuStall,
    // Flash array port
    output logic             flashRdEn,
    output logic [20:0]      flashRdAddr,
    input  wire logic [15:0] flashRdData,
    output logic             flashWrEn,
    output logic [19:0]      flashWrAddr,
    output logic [15:0]      flashWrData,
    output logic             flashEraseEn,
    output logic [10:0]      flashRowAddr
);
    localparam logic [31:0] ERASE_CNT = 32'(ERASE_CYCLES);
    localparam logic [31:0] PROG_CNT  = 32'(PROG_CYCLES);

    seq_st_t              state_ff;
    logic [PTR_W-1:0]     flashBytePointer_ff;
    logic [7:0]           latch_ff;
    logic                 eraseSel_ff, abort_ff, writeAllow_ff, start_ff;
    logic                 got55_ff, armed_ff;
    logic [7:0]           hold_ff [HOLD_N];
    logic [4:0]           wordIdx_ff;
    logic [31:0]          timer_ff;
    logic                 byteSel_ff;
    logic                 awHeld_ff, wHeld_ff;
    logic [3:0]           awAddr_ff;
    logic [31:0]          wData_ff;
    logic [3:0]           wStrb_ff;
    logic                 awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]           bresp_ff, rresp_ff;
    logic [31:0]          rdata_ff;
    logic                 tblDone_ff, stall_ff;
    logic                 flashRdEn_ff, flashWrEn_ff, flashEraseEn_ff;
    logic [20:0]          flashRdAddr_ff;
    logic [19:0]          flashWrAddr_ff;
    logic [15:0]          flashWrData_ff;
    logic [10:0]          flashRowAddr_ff;

    // Bus write decode
    wire         awHave   = awHeld_ff | (awvalid & awready_ff);
    wire         wHave    = wHeld_ff | (wvalid & wready_ff);
    wire [3:0]   wrAddr   = awHeld_ff ? awAddr_ff : awaddr;
    wire [31:0]  wrData   = wHeld_ff ? wData_ff : wdata;
    wire [3:0]   wrStrb   = wHeld_ff ? wStrb_ff : wstrb;
    wire         wrFire   = awHave & wHave & ~bvalid_ff;
    wire [31:0]  strbMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
    wire         wrCtrl   = wrFire & (wrAddr == CTRL_OFS) & wrStrb[0];
    wire         wrKey    = wrFire & (wrAddr == KEY_OFS) & wrStrb[0];
    wire         wrPtr    = wrFire & (wrAddr == PTR_OFS);
    wire         wrLatch  = wrFire & (wrAddr == LATCH_OFS) & wrStrb[0];
    wire         wrMapped = (wrAddr == CTRL_OFS) | (wrAddr == KEY_OFS)
                          | (wrAddr == PTR_OFS) | (wrAddr == LATCH_OFS);
    wire         idle     = (state_ff == ST_IDLE);

    // Start request qualified by the two keys written just before
    wire startReq = wrCtrl & wrData[START_BIT] & idle;
    wire startOk  = startReq & armed_ff & writeAllow_ff;
    wire startBad = startReq & ~startOk;

    // Table operation and pointer arithmetic
    wire                 tblGo    = tblReq & idle & ~startOk;
    wire [PTR_W-1:0]     ptrInc   = {flashBytePointer_ff[PTR_W-1],
                                     flashBytePointer_ff[ADDR_MSB:0] + 21'h000001};
    wire [PTR_W-1:0]     ptrDec   = {flashBytePointer_ff[PTR_W-1],
                                     flashBytePointer_ff[ADDR_MSB:0] - 21'h000001};
    wire [PTR_W-1:0]     effAddr  = (tblMode == PM_PREINC) ? ptrInc : flashBytePointer_ff;
    wire [PTR_W-1:0]     ptrAfter = (tblMode == PM_KEEP) ? flashBytePointer_ff
                                  : (tblMode == PM_POSTDEC) ? ptrDec : ptrInc;
    wire                 lastWord = (wordIdx_ff == 5'(WORDS_BLK - 1));
    wire                 timerEnd = (timer_ff == 32'h00000000);

    // Read mux
    wire [31:0] ctrlRd = {27'h0, eraseSel_ff, abort_ff, writeAllow_ff, start_ff, 1'b0};
    wire [31:0] rdMux  = (araddr == CTRL_OFS)  ? ctrlRd
                       : (araddr == PTR_OFS)   ? {10'h0, flashBytePointer_ff}
                       : (araddr == LATCH_OFS) ? {24'h0, latch_ff}
                       : 32'h00000000;
    wire        rdMapped = (araddr == CTRL_OFS) | (araddr == KEY_OFS)
                         | (araddr == PTR_OFS) | (araddr == LATCH_OFS);

    // Program word from holding registers, low byte at even address
    wire [15:0] progWord = {hold_ff[{wordIdx_ff, 1'b1}], hold_ff[{wordIdx_ff, 1'b0}]};

    // AXI write channel handshake
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_ff  <= 1'b0;
            wHeld_ff   <= 1'b0;
            awAddr_ff  <= 4'h0;
            wData_ff   <= 32'h00000000;
            wStrb_ff   <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (awvalid & awready_ff) begin
                awAddr_ff <= awaddr;
            end
            if (wvalid & wready_ff) begin
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
            awHeld_ff  <= awHave & ~wrFire;
            wHeld_ff   <= wHave & ~wrFire;
            awready_ff <= ~(awHave & ~wrFire) & ~(bvalid_ff & ~bready) & ~wrFire;
            wready_ff  <= ~(wHave & ~wrFire) & ~(bvalid_ff & ~bready) & ~wrFire;
            if (wrFire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // AXI read channel, answer one cycle after address
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= RESP_OKAY;
        end else if (arvalid & arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rdMux;
            rresp_ff   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff & rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Unlock key tracker, any other write breaks the sequence
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            got55_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (wrFire) begin
            got55_ff <= wrKey & (wrData[7:0] == KEY_FIRST);
            armed_ff <= wrKey & (wrData[7:0] == KEY_SECOND) & got55_ff;
        end
    end

    // Control bits; hardware set wins over software clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eraseSel_ff   <= 1'b0;
            abort_ff      <= 1'b0;
            writeAllow_ff <= 1'b0;
            start_ff      <= 1'b0;
        end else begin
            if (wrCtrl & idle) begin
                eraseSel_ff   <= wrData[ERASE_SEL_BIT];
                writeAllow_ff <= wrData[WALLOW_BIT];
                abort_ff      <= wrData[ABORT_BIT];
            end
            if (startOk) begin
                start_ff <= 1'b1;
                abort_ff <= 1'b1;
            end else if (startBad) begin
                abort_ff <= 1'b1;
            end
            if (state_ff == ST_WAIT && timerEnd) begin
                start_ff    <= 1'b0;
                abort_ff    <= 1'b0;
                eraseSel_ff <= 1'b0;
            end
        end
    end

    // Pointer and table latch
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flashBytePointer_ff <= '0;
            latch_ff            <= 8'h00;
            byteSel_ff          <= 1'b0;
        end else begin
            if (tblGo) begin
                flashBytePointer_ff <= ptrAfter;
                byteSel_ff          <= effAddr[0];
            end else if (wrPtr & idle) begin
                flashBytePointer_ff <= PTR_W'((32'(flashBytePointer_ff) & ~strbMask)
                                              | (wrData & strbMask));
            end
            if (state_ff == ST_RD2) begin
                latch_ff <= byteSel_ff ? flashRdData[15:8] : flashRdData[7:0];
            end else if (wrLatch) begin
                latch_ff <= wrData[7:0];
            end
        end
    end

    // Holding registers, deliberately without reset
    always_ff @(posedge mclk) begin
        if (tblGo & tblWrite) begin
            hold_ff[effAddr[BLK_LSB-1:0]] <= latch_ff;
        end
    end

    // Sequencer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff        <= ST_IDLE;
            wordIdx_ff      <= 5'h00;
            timer_ff        <= 32'h00000000;
            tblDone_ff      <= 1'b0;
            stall_ff        <= 1'b0;
            flashRdEn_ff    <= 1'b0;
            flashRdAddr_ff  <= 21'h000000;
            flashWrEn_ff    <= 1'b0;
            flashWrAddr_ff  <= 20'h00000;
            flashWrData_ff  <= 16'h0000;
            flashEraseEn_ff <= 1'b0;
            flashRowAddr_ff <= 11'h000;
        end else begin
            tblDone_ff      <= 1'b0;
            flashRdEn_ff    <= 1'b0;
            flashWrEn_ff    <= 1'b0;
            flashEraseEn_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (startOk && eraseSel_ff) begin
                        state_ff        <= ST_ERASE;
                        stall_ff        <= 1'b1;
                        flashRowAddr_ff <= flashBytePointer_ff[ADDR_MSB:ROW_LSB];
                    end else if (startOk) begin
                        state_ff   <= ST_PROG;
                        stall_ff   <= 1'b1;
                        wordIdx_ff <= 5'h00;
                    end else if (tblGo && tblWrite) begin
                        tblDone_ff <= 1'b1;
                    end else if (tblGo) begin
                        state_ff       <= ST_RD1;
                        flashRdEn_ff   <= 1'b1;
                        flashRdAddr_ff <= effAddr[PTR_W-1:1];
                    end
                end
                ST_RD1: state_ff <= ST_RD2;
                ST_RD2: begin
                    state_ff   <= ST_IDLE;
                    tblDone_ff <= 1'b1;
                end
                ST_ERASE: begin
                    flashEraseEn_ff <= 1'b1;
                    timer_ff        <= ERASE_CNT - 32'h00000001;
                    state_ff        <= ST_WAIT;
                end
                ST_PROG: begin
                    flashWrEn_ff   <= 1'b1;
                    flashWrAddr_ff <= {flashBytePointer_ff[ADDR_MSB:BLK_LSB], wordIdx_ff};
                    flashWrData_ff <= progWord;
                    wordIdx_ff     <= wordIdx_ff + 5'h01;
                    if (lastWord) begin
                        timer_ff <= PROG_CNT - 32'h00000001;
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (timerEnd) begin
                        state_ff <= ST_IDLE;
                        stall_ff <= 1'b0;
                    end else begin
                        timer_ff <= timer_ff - 32'h00000001;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Outputs straight from flops
    assign awready        = awready_ff;
    assign wready         = wready_ff;
    assign bvalid         = bvalid_ff;
    assign bresp          = bresp_ff;
    assign arready        = arready_ff;
    assign rvalid         = rvalid_ff;
    assign rdata          = rdata_ff;
    assign rresp          = rresp_ff;
    assign tblDone        = tblDone_ff;
    assign tableByteLatch = latch_ff;
    assign cpuStall       = stall_ff;
    assign flashRdEn      = flashRdEn_ff;
    assign flashRdAddr    = flashRdAddr_ff;
    assign flashWrEn      = flashWrEn_ff;
    assign flashWrAddr    = flashWrAddr_ff;
    assign flashWrData    = flashWrData_ff;
    assign flashEraseEn   = flashEraseEn_ff;
    assign flashRowAddr   = flashRowAddr_ff;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_second_key;
        wrKey && wrData[7:0] == KEY_SECOND;
    endsequence
    property p_start_stall;
        startOk |=> cpuStall && start_ff;
    endproperty
    a_start_stall: assert property (p_start_stall) else $error("stall missing after start");
    property p_need_key;
        startReq && !armed_ff |=> !cpuStall;
    endproperty
    a_need_key: assert property (p_need_key) else $error("start without keys accepted");
    property p_key_arms;
        got55_ff ##0 s_second_key |=> armed_ff;
    endproperty
    a_key_arms: assert property (p_key_arms) else $error("key sequence did not arm");
    property p_key_zero;
        arvalid && arready && araddr == KEY_OFS |=> rdata == 32'h00000000;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key register read not zero");
    property p_rd_byte;
        state_ff == ST_RD2 |=> tblDone && tableByteLatch ==
            (byteSel_ff ? $past(flashRdData[15:8]) : $past(flashRdData[7:0]));
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("wrong byte in latch");
    property p_erase_row;
        flashEraseEn |-> flashRowAddr == flashBytePointer_ff[ADDR_MSB:ROW_LSB] && eraseSel_ff;
    endproperty
    a_erase_row: assert property (p_erase_row) else $error("erase row mismatch");
    property p_prog_block;
        $rose(flashWrEn) |-> flashWrEn[*8] ##0 flashWrAddr[4:0] == 5'h07;
    endproperty
    a_prog_block: assert property (p_prog_block) else $error("block write not contiguous");
    property p_start_clear;
        $fell(cpuStall) |-> !start_ff && !eraseSel_ff;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start or erase bit stuck");
    property p_ptr_inc;
        tblGo && tblMode == PM_POSTINC |=>
            flashBytePointer_ff[ADDR_MSB:0] == $past(flashBytePointer_ff[ADDR_MSB:0]) + 21'h1;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");
endmodule

/* File: rtl/flash_seq_pkg.sv */
// Functional notes
// - Table read loads one addressed byte
// - Table ops optionally step the pointer
// - Pointer bit 0 picks word byte
// - Erase clears 1024-byte row, pointer 20:10
// - No word erase, no bulk erase
// - Start needs 55h then 0AAh keys
// - Start runs erase or block write
// - Core stalled during long cycle
// - Internal timer ends long cycle
// - Program whole 64-byte block only
// - Table writes fill holding registers only
// - Holding registers never reset
// - Pointer 5:0 picks holding, 20:6 block
// - Start bit set-only, cleared by hardware
// - Erase select cleared after erase
// - Unlock key register reads zero
package flash_seq_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFS  = 4'h0;
    localparam logic [3:0] KEY_OFS   = 4'h4;
    localparam logic [3:0] PTR_OFS   = 4'h8;
    localparam logic [3:0] LATCH_OFS = 4'hC;
    // Control register fields
    localparam int ERASE_SEL_BIT = 4;
    localparam int ABORT_BIT     = 3;
    localparam int WALLOW_BIT    = 2;
    localparam int START_BIT     = 1;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Geometry
    localparam int PTR_W     = 22;
    localparam int HOLD_N    = 64;
    localparam int WORDS_BLK = 32;
    localparam int BLK_LSB   = 6;
    localparam int ROW_LSB   = 10;
    localparam int ADDR_MSB  = 20;
    // Long cycle timing at 200 MHz
    localparam int CLK_MHZ          = 200;
    localparam int ERASE_TIME_US    = 20;
    localparam int PROG_TIME_US     = 10;
    localparam int ERASE_CYC_DEF    = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYC_DEF     = PROG_TIME_US * CLK_MHZ;
    // Table pointer modes
    typedef enum logic [1:0] {PM_KEEP, PM_POSTINC, PM_POSTDEC, PM_PREINC} ptr_mode_t;
    // Sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_RD1, ST_RD2, ST_ERASE, ST_PROG, ST_WAIT} seq_st_t;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: testbench/flash_array_model.sv */
// Behavioural flash array on the sequencer's far side
module flash_array_model
    import flash_seq_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Flash array port
    input  wire logic        flashRdEn,
    input  wire logic [20:0] flashRdAddr,
    output logic      [15:0] flashRdData,
    input  wire logic        flashWrEn,
    input  wire logic [19:0] flashWrAddr,
    input  wire logic [15:0] flashWrData,
    input  wire logic        flashEraseEn,
    input  wire logic [10:0] flashRowAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [int];
    int          wrCount = 0;
    int          eraseCount = 0;
    initial flashRdData = 16'h0000;
    // Sync read, pattern changes while unselected
    always @(posedge mclk) begin
        if (flashRdEn) begin
            flashRdData <= mem.exists(int'(flashRdAddr)) ? mem[int'(flashRdAddr)] : 16'hFFFF;
        end else begin
            flashRdData <= ~flashRdData;
        end
    end
    // Programming only clears bits, erase drops a whole row
    always @(posedge mclk) begin
        if (flashWrEn) begin
            wrCount++;
            mem[int'(flashWrAddr)] = (mem.exists(int'(flashWrAddr)) ?
                mem[int'(flashWrAddr)] : 16'hFFFF) & flashWrData;
        end
        if (flashEraseEn) begin
            eraseCount++;
            foreach (mem[k]) if (k[19:9] == flashRowAddr) mem.delete(k);
        end
    end
endmodule

/* File: testbench/tb_flash_self_program_sequencer.sv */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_flash_self_program_sequencer
    import flash_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ERASE_N = 6;
    localparam int PROG_N  = 8;
    logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready, tblReq, tblWrite;
    logic        awready, wready, bvalid, arready, rvalid, tblDone, cpuStall;
    logic [3:0]  awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r, tblMode;
    logic [7:0]  tableByteLatch;
    logic        flashRdEn, flashWrEn, flashEraseEn;
    logic [20:0] flashRdAddr;
    logic [19:0] flashWrAddr;
    logic [15:0] flashRdData, flashWrData;
    logic [10:0] flashRowAddr;
    int          failCount = 0;
    int          checked = 0;
    int          stallCyc = 0;
    flash_self_program_sequencer #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N))
    flash_self_program_sequencer_i (.mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .tblReq(tblReq), .tblWrite(tblWrite), .tblMode(tblMode),
        .tblDone(tblDone), .tableByteLatch(tableByteLatch), .cpuStall(cpuStall),
        .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
        .flashEraseEn(flashEraseEn), .flashRowAddr(flashRowAddr));
    flash_array_model flash_array_model_i (.mclk(mclk), .flashRdEn(flashRdEn),
        .flashRdAddr(flashRdAddr), .flashRdData(flashRdData), .flashWrEn(flashWrEn),
        .flashWrAddr(flashWrAddr), .flashWrData(flashWrData), .flashEraseEn(flashEraseEn),
        .flashRowAddr(flashRowAddr));
    // Clock and stall length counter
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (cpuStall === 1'b1) stallCyc++;
    // Verdict and end of run
    task automatic closeOut();
        $display("mismatches %0d, comparisons %0d", failCount, checked);
        if (failCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // AXI4-Lite write, both channels offered together
    task automatic axiWr(input logic [3:0] a, input logic [31:0] v);
        bit awd;
        bit wd;
        awd = 0;
        wd = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) begin awd = 1; awvalid <= 1'b0; end
            if (wvalid && wready) begin wd = 1; wvalid <= 1'b0; end
        end while (!(awd && wd));
        do @(posedge mclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge mclk);
    endtask
    // AXI4-Lite read
    task automatic axiRd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask
    // One core table instruction
    task automatic tbl(input logic wr, input logic [1:0] m);
        tblReq <= 1'b1;
        tblWrite <= wr;
        tblMode <= m;
        @(posedge mclk);
        tblReq <= 1'b0;
        do @(posedge mclk); while (tblDone !== 1'b1);
        @(posedge mclk);
    endtask
    // Unlock and start, then let the long cycle run out
    task automatic launch(input logic [31:0] ptr, input logic [31:0] ctl, input bit good);
        axiWr(PTR_OFS, ptr);
        axiWr(CTRL_OFS, ctl);
        axiWr(KEY_OFS, good ? 32'h55 : 32'hAA);
        axiWr(KEY_OFS, good ? 32'hAA : 32'h55);
        stallCyc = 0;
        axiWr(CTRL_OFS, ctl | 32'h2);
        repeat (80) @(posedge mclk);
    endtask
    // Compare one programmed 64-byte block in the array
    task automatic chkBlock(input int wbase);
        for (int i = 0; i < WORDS_BLK; i++) begin
            `CHK(flash_array_model_i.mem[wbase + i], {8'(2*i+1) ^ 8'h3C, 8'(2*i) ^ 8'h3C})
        end
    endtask
    initial begin
        #50000;
        failCount++;
        closeOut();
    end
    // Table read modes: mode, expected latch, expected pointer
    logic [1:0] mSeq [5] = '{2'd1, 2'd1, 2'd3, 2'd2, 2'd0};
    logic [7:0] lSeq [5] = '{8'h5A, 8'hA5, 8'h12, 8'h12, 8'h34};
    logic [31:0] pSeq [5] = '{32'h101, 32'h102, 32'h103, 32'h102, 32'h102};
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, tblReq, tblWrite} = '0;
        {awaddr, araddr, wstrb, wdata, tblMode} = '0;
        sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        axiRd(CTRL_OFS); `CHK(d, 32'h0)
        axiWr(KEY_OFS, 32'h55); `CHK(r, RESP_OKAY)
        axiRd(KEY_OFS); `CHK(d, 32'h0)
        axiRd(4'h2); `CHK(r, RESP_SLVERR)
        axiWr(4'h2, 32'h0); `CHK(r, RESP_SLVERR)
        flash_array_model_i.mem['h80] = 16'hA55A;
        flash_array_model_i.mem['h81] = 16'h1234;
        axiWr(PTR_OFS, 32'h100);
        for (int k = 0; k < 5; k++) begin
            tbl(1'b0, mSeq[k]);
            `CHK(tableByteLatch, lSeq[k])
            axiRd(PTR_OFS); `CHK(d, pSeq[k])
        end
        axiWr(PTR_OFS, 32'h1000);
        for (int j = 0; j < HOLD_N; j++) begin
            axiWr(LATCH_OFS, 32'(j ^ 8'h3C));
            tbl(1'b1, 2'd1);
        end
        `CHK(flash_array_model_i.wrCount, 0)
        launch(32'h1005, 32'h4, 1'b1);
        `CHK(flash_array_model_i.wrCount, 32)
        `CHK(stallCyc >= 32 + PROG_N && stallCyc <= 34 + PROG_N, 1'b1)
        axiRd(CTRL_OFS); `CHK(d, 32'h4)
        chkBlock('h800);
        axiWr(PTR_OFS, 32'h1001);
        tbl(1'b0, 2'd0); `CHK(tableByteLatch, 8'h01 ^ 8'h3C)
        launch(32'h1040, 32'h4, 1'b1);
        chkBlock('h820);
        flash_array_model_i.mem['hA00] = 16'h0F0F;
        launch(32'h13FF, 32'h14, 1'b1);
        `CHK(flash_array_model_i.eraseCount, 1)
        `CHK(stallCyc >= 1 + ERASE_N && stallCyc <= 3 + ERASE_N, 1'b1)
        `CHK(flash_array_model_i.mem.exists('h800) || flash_array_model_i.mem.exists('h83F),
            1'b0)
        `CHK(flash_array_model_i.mem['hA00], 16'h0F0F)
        axiRd(CTRL_OFS); `CHK(d, 32'h4)
        axiWr(CTRL_OFS, 32'h14);
        axiWr(KEY_OFS, 32'h55);
        axiWr(PTR_OFS, 32'h1000);
        axiWr(KEY_OFS, 32'hAA);
        stallCyc = 0;
        axiWr(CTRL_OFS, 32'h16);
        repeat (20) @(posedge mclk);
        `CHK(stallCyc, 0)
        axiRd(CTRL_OFS); `CHK(d, 32'h1C)
        launch(32'h1000, 32'h14, 1'b0);
        launch(32'h1000, 32'h10, 1'b1);
        `CHK(flash_array_model_i.eraseCount, 1)
        `CHK(stallCyc, 0)
        closeOut();
    end
endmodule
